// File: rtl/drive_status_output_select.sv
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/1ps
// Operation
// RULE1 - Two independent selects route one of eighteen conditions to each output
// RULE2 - Code 0: commanded and output frequency differ by at most half bandwidth
// RULE3 - Bandwidth 0 to 400 Hz, default 10.0, refused above max frequency
// RULE4 - Detection level 0 to 400 Hz, default 30.0, refused above max frequency
// RULE5 - Code 1: commanded frequency equals level and code 0 holds
// RULE6 - Code 2: level and running frequency within half bandwidth
// RULE7 - Code 3: set at level, held while above level minus half bandwidth
// RULE8 - Code 4 is the inverse of code 3
// RULE9 - Code 8 follows the overvoltage trip
// RULE10 - Code 9 follows the undervoltage trip
// RULE11 - Code 10 follows heatsink overheat protection
// RULE12 - Code 11 follows frequency reference loss
// RULE13 - Code 12 while run command present and output voltage produced
// RULE14 - Code 13 while stopped, code 14 while at constant speed
// RULE15 - Code 16 while waiting for a run command
// RULE16 - Code 17 drives output from trip classes enabled in fault mask
// RULE17 - Mask bit 0 undervoltage, bit 1 other trips, bit 2 restart retries
// RULE18 - Mask 2 on code 17 asserts on every trip except undervoltage
// RULE19 - Code 5 carries the overload warning
// RULE20 - Warning level 30 to 150 percent default 150, time 0 to 30 s default 10
// RULE21 - Warning after current above level for full time, clears below level
// RULE22 - Overload trip works only when enabled, then switches output off
// RULE23 - Trip after current above level for trip time; 30-200 percent, 0-60 s
// RULE24 - Trip timer restarts when current drops below trip level
module drive_status_output_select
   import drive_status_pkg::*;
#(
   parameter int SEC_TICKS = SEC_CYCLES
)
(
   // Clock and reset
   input  wire logic                          sys_clk_in,
   input  wire logic                          rst_in,
   // APB slave
   input  wire drive_status_pkg::apb_req_t    apb_in,
   output logic [31:0]                        prdata_out,
   output logic                               pready_out,
   output logic                               pslverr_out,
   // Drive state, same clock domain
   input  wire drive_status_pkg::drive_stat_t drive_in,
   // Status outputs
   output logic                               transistor_status_out,
   output logic                               relay_status_out,
   output logic                               motor_overload_flag_out,
   output logic                               output_off_out
);
   import drive_status_pkg::*;

   typedef struct packed {
      logic [11:0] lvl;
      logic [11:0] bw;
      logic [11:0] maxf;
      logic [4:0]  tsel;
      logic [4:0]  rsel;
      logic [2:0]  fmask;
      logic [7:0]  wlvl;
      logic [5:0]  wtime;
      logic        ten;
      logic [7:0]  tlvl;
      logic [5:0]  ttime;
      logic        tripped;
      logic        warn;
      logic [26:0] wpre;
      logic [5:0]  wsec;
      logic [26:0] tpre;
      logic [5:0]  tsec;
      logic        fdt4;
      logic        tout;
      logic        rout;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } state_t;

   state_t s_q;
   state_t s_d;

   logic [17:0] cond;
   logic [11:0] half_bw;
   logic [11:0] cmd_diff;
   logic [11:0] lvl_diff;
   logic [12:0] run_plus;
   logic        warn_above;
   logic        trip_above;
   logic        access;
   logic        wr_en;
   logic        wr_bad;
   logic [31:0] rd_val;
   logic        rd_bad;

   function automatic logic [11:0] abs_diff(input logic [11:0] a, input logic [11:0] b);
      abs_diff = (a > b) ? (a - b) : (b - a);
   endfunction

   function automatic logic pct_ok(input logic [31:0] v, input logic [7:0] lo,
                                   input logic [7:0] hi);
      pct_ok = (v[31:8] == 24'h000000) && (v[7:0] >= lo) && (v[7:0] <= hi);
   endfunction

   // Status conditions
   always_comb
   begin
      half_bw  = {1'b0, s_q.bw[11:1]};
      cmd_diff = abs_diff(drive_in.cmd_freq, drive_in.run_freq);
      lvl_diff = abs_diff(s_q.lvl, drive_in.run_freq);
      run_plus = {1'b0, drive_in.run_freq} + {1'b0, half_bw};
      cond     = '0;
      cond[0]  = (cmd_diff <= half_bw); // RULE2
      cond[1]  = (drive_in.cmd_freq == s_q.lvl) && cond[0]; // RULE5
      cond[2]  = (lvl_diff <= half_bw); // RULE6
      cond[3]  = s_q.fdt4; // RULE7
      cond[4]  = ~s_q.fdt4; // RULE8
      cond[5]  = s_q.warn; // RULE19
      cond[6]  = drive_in.drive_overload_flag;
      cond[7]  = drive_in.stall;
      cond[8]  = drive_in.ov_trip; // RULE9
      cond[9]  = drive_in.uv_trip; // RULE10
      cond[10] = drive_in.heatsink_hot_flag; // RULE11
      cond[11] = drive_in.ref_lost; // RULE12
      cond[12] = drive_in.run_cmd && drive_in.output_on; // RULE13
      cond[13] = drive_in.stopped; // RULE14
      cond[14] = drive_in.const_speed; // RULE14
      cond[15] = drive_in.speed_search;
      cond[16] = drive_in.waiting_run; // RULE15
      cond[17] = (s_q.fmask[0] && drive_in.uv_trip) // RULE16
               | (s_q.fmask[1] && drive_in.other_trip) // RULE17
               | (s_q.fmask[2] && drive_in.retry_active); // RULE18
   end

   // Register read mux
   always_comb
   begin
      rd_val = '0;
      rd_bad = 1'b0;
      case (apb_in.paddr)
         OFS_LEVEL:  rd_val[11:0] = s_q.lvl;
         OFS_BW:     rd_val[11:0] = s_q.bw;
         OFS_MAXF:   rd_val[11:0] = s_q.maxf;
         OFS_SEL:
         begin
            rd_val[4:0]                = s_q.tsel;
            rd_val[SEL_RELAY_LSB +: 5] = s_q.rsel;
         end
         OFS_FMASK:  rd_val[2:0] = s_q.fmask;
         OFS_WARN:
         begin
            rd_val[7:0]                = s_q.wlvl;
            rd_val[OL_TIME_LSB +: 6]   = s_q.wtime;
         end
         OFS_TRIP:
         begin
            rd_val[7:0]                = s_q.tlvl;
            rd_val[OL_TIME_LSB +: 6]   = s_q.ttime;
            rd_val[OL_EN_BIT]          = s_q.ten;
         end
         OFS_CTRL:   rd_val = '0;
         OFS_STATUS:
         begin
            rd_val[17:0]               = cond;
            rd_val[STAT_TRIP_BIT]      = s_q.tripped;
            rd_val[STAT_WARN_BIT]      = s_q.warn;
         end
         default:    rd_bad = 1'b1;
      endcase
   end

   // Write checks; a refused write stores nothing and answers with an error
   always_comb
   begin
      wr_bad = 1'b0;
      case (apb_in.paddr)
         OFS_LEVEL:  wr_bad = (apb_in.pwdata > {20'h0, s_q.maxf});       // RULE4
         OFS_BW:     wr_bad = (apb_in.pwdata > {20'h0, s_q.maxf});       // RULE3
         OFS_MAXF:   wr_bad = (apb_in.pwdata > {20'h0, FREQ_LIMIT});
         OFS_SEL:    wr_bad = (apb_in.pwdata[4:0] > SEL_MAX)
                            || (apb_in.pwdata[SEL_RELAY_LSB +: 5] > SEL_MAX);
         OFS_FMASK:  wr_bad = 1'b0;
         OFS_WARN:   wr_bad = !pct_ok({24'h0, apb_in.pwdata[7:0]},       // RULE20
                                      WARN_LVL_MIN, WARN_LVL_MAX)
                            || (apb_in.pwdata[OL_TIME_LSB +: 6] > WARN_T_MAX);
         OFS_TRIP:   wr_bad = !pct_ok({24'h0, apb_in.pwdata[7:0]},       // RULE23
                                      TRIP_LVL_MIN, TRIP_LVL_MAX)
                            || (apb_in.pwdata[OL_TIME_LSB +: 6] > TRIP_T_MAX);
         OFS_CTRL:   wr_bad = 1'b0;
         default:    wr_bad = 1'b1;
      endcase
   end

   always_comb
   begin
      s_d        = s_q;
      access     = apb_in.psel && apb_in.penable;
      wr_en      = access && s_q.pready && apb_in.pwrite && !wr_bad;
      warn_above = (drive_in.motor_current > s_q.wlvl);
      trip_above = (drive_in.motor_current > s_q.tlvl);

      // One wait state: ready rises in the second access cycle
      s_d.pready  = access && !s_q.pready;
      s_d.pslverr = access && !s_q.pready && (apb_in.pwrite ? wr_bad : rd_bad);
      s_d.prdata  = (access && !s_q.pready && !apb_in.pwrite) ? rd_val : '0;

      if (wr_en)
      begin
         case (apb_in.paddr)
            OFS_LEVEL: s_d.lvl  = apb_in.pwdata[11:0];                  // RULE4
            OFS_BW:    s_d.bw   = apb_in.pwdata[11:0];                  // RULE3
            OFS_MAXF:  s_d.maxf = apb_in.pwdata[11:0];
            OFS_SEL:
            begin
               s_d.tsel = apb_in.pwdata[4:0];                           // RULE1
               s_d.rsel = apb_in.pwdata[SEL_RELAY_LSB +: 5];            // RULE1
            end
            OFS_FMASK: s_d.fmask = apb_in.pwdata[2:0];                  // RULE17
            OFS_WARN:
            begin
               s_d.wlvl  = apb_in.pwdata[7:0];                          // RULE20
               s_d.wtime = apb_in.pwdata[OL_TIME_LSB +: 6];             // RULE20
            end
            OFS_TRIP:
            begin
               s_d.tlvl  = apb_in.pwdata[7:0];                          // RULE23
               s_d.ttime = apb_in.pwdata[OL_TIME_LSB +: 6];             // RULE23
               s_d.ten   = apb_in.pwdata[OL_EN_BIT];                    // RULE22
            end
            default:   s_d.lvl = s_q.lvl;
         endcase
      end

      // Trip clear by software; a trip in the same cycle wins below
      if (wr_en && (apb_in.paddr == OFS_CTRL) && apb_in.pwdata[CTRL_CLR_BIT])
      begin
         s_d.tripped = 1'b0;
      end

      // Hysteresis keeps code 3 from chattering near the level
      if (drive_in.run_freq >= s_q.lvl)                                 // RULE7
      begin
         s_d.fdt4 = 1'b1;
      end
      else if (run_plus <= {1'b0, s_q.lvl})                             // RULE7
      begin
         s_d.fdt4 = 1'b0;
      end

      // Warning timer, prescaler restarts so each second is whole
      if (warn_above)
      begin
         if (s_q.wsec >= s_q.wtime)
         begin
            s_d.warn = 1'b1;                                            // RULE21
         end
         else if (s_q.wpre == 27'(SEC_TICKS - 1))
         begin
            s_d.wpre = '0;
            s_d.wsec = s_q.wsec + 6'h01;
         end
         else
         begin
            s_d.wpre = s_q.wpre + 27'h0000001;
         end
      end
      else
      begin
         s_d.warn = 1'b0;                                               // RULE21
         s_d.wpre = '0;
         s_d.wsec = '0;
      end

      // Overload trip timer
      if (s_q.ten && trip_above && !s_q.tripped)                        // RULE22
      begin
         if (s_q.tsec >= s_q.ttime)
         begin
            s_d.tripped = 1'b1;                                         // RULE23
            s_d.tpre    = '0;
            s_d.tsec    = '0;
         end
         else if (s_q.tpre == 27'(SEC_TICKS - 1))
         begin
            s_d.tpre = '0;
            s_d.tsec = s_q.tsec + 6'h01;
         end
         else
         begin
            s_d.tpre = s_q.tpre + 27'h0000001;
         end
      end
      else
      begin
         s_d.tpre = '0;                                                 // RULE24
         s_d.tsec = '0;                                                 // RULE24
      end

      s_d.tout = cond[s_q.tsel];                                        // RULE1
      s_d.rout = cond[s_q.rsel];                                        // RULE1
   end

   always_ff @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         s_q         <= '0;
         s_q.lvl     <= RST_LEVEL;
         s_q.bw      <= RST_BW;
         s_q.maxf    <= RST_MAXF;
         s_q.tsel    <= RST_TR_SEL;
         s_q.rsel    <= RST_RL_SEL;
         s_q.fmask   <= RST_FMASK;
         s_q.wlvl    <= RST_WARN_LVL;
         s_q.wtime   <= RST_WARN_T;
         s_q.ten     <= RST_TRIP_EN;
         s_q.tlvl    <= RST_TRIP_LVL;
         s_q.ttime   <= RST_TRIP_T;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign prdata_out              = s_q.prdata;
   assign pready_out              = s_q.pready;
   assign pslverr_out             = s_q.pslverr;
   assign transistor_status_out   = s_q.tout;
   assign relay_status_out        = s_q.rout;
   assign motor_overload_flag_out = s_q.warn;
   assign output_off_out          = s_q.tripped;                        // RULE22

endmodule

// File: rtl/drive_status_pkg.sv
package drive_status_pkg;

   // Timing
   localparam int CLK_HZ         = 100_000_000;
   localparam int SEC_UNIT_S     = 1;
   localparam int SEC_CYCLES     = SEC_UNIT_S * CLK_HZ;

   // Register byte offsets
   localparam logic [7:0] OFS_LEVEL  = 8'h00;
   localparam logic [7:0] OFS_BW     = 8'h04;
   localparam logic [7:0] OFS_MAXF   = 8'h08;
   localparam logic [7:0] OFS_SEL    = 8'h0C;
   localparam logic [7:0] OFS_FMASK  = 8'h10;
   localparam logic [7:0] OFS_WARN   = 8'h14;
   localparam logic [7:0] OFS_TRIP   = 8'h18;
   localparam logic [7:0] OFS_CTRL   = 8'h1C;
   localparam logic [7:0] OFS_STATUS = 8'h20;

   // Field positions
   localparam int SEL_RELAY_LSB  = 8;
   localparam int OL_TIME_LSB    = 8;
   localparam int OL_EN_BIT      = 16;
   localparam int CTRL_CLR_BIT   = 0;
   localparam int STAT_TRIP_BIT  = 24;
   localparam int STAT_WARN_BIT  = 25;

   // Frequencies in 0.1 Hz steps
   localparam logic [11:0] FREQ_LIMIT    = 12'hFA0;
   localparam logic [11:0] RST_LEVEL     = 12'h12C;
   localparam logic [11:0] RST_BW        = 12'h064;
   localparam logic [11:0] RST_MAXF      = 12'h258;

   // Selections and masks
   localparam logic [4:0]  SEL_MAX       = 5'h11;
   localparam logic [4:0]  RST_TR_SEL    = 5'h0C;
   localparam logic [4:0]  RST_RL_SEL    = 5'h11;
   localparam logic [2:0]  RST_FMASK     = 3'h2;

   // Overload, current in percent of motor rating, time in seconds
   localparam logic [7:0]  WARN_LVL_MIN  = 8'h1E;
   localparam logic [7:0]  WARN_LVL_MAX  = 8'h96;
   localparam logic [7:0]  RST_WARN_LVL  = 8'h96;
   localparam logic [5:0]  WARN_T_MAX    = 6'h1E;
   localparam logic [5:0]  RST_WARN_T    = 6'h0A;
   localparam logic [7:0]  TRIP_LVL_MIN  = 8'h1E;
   localparam logic [7:0]  TRIP_LVL_MAX  = 8'hC8;
   localparam logic [7:0]  RST_TRIP_LVL  = 8'hB4;
   localparam logic [5:0]  TRIP_T_MAX    = 6'h3C;
   localparam logic [5:0]  RST_TRIP_T    = 6'h3C;
   localparam logic        RST_TRIP_EN   = 1'b0;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic [11:0] cmd_freq;
      logic [11:0] run_freq;
      logic [7:0]  motor_current;
      logic        run_cmd;
      logic        output_on;
      logic        stopped;
      logic        const_speed;
      logic        waiting_run;
      logic        ov_trip;
      logic        uv_trip;
      logic        other_trip;
      logic        retry_active;
      logic        heatsink_hot_flag;
      logic        ref_lost;
      logic        drive_overload_flag;
      logic        stall;
      logic        speed_search;
   } drive_stat_t;

endpackage

// File: test/drive_seq_model.sv
`timescale 1ns/1ps
// External control sequence: presents drive state on the clock edge, watches the contacts
module drive_seq_model
   import drive_status_pkg::*;
(
   // Clock and reset
   input  wire logic                          sys_clk_in,
   input  wire logic                          rst_in,
   // Requested drive state and contacts read back
   input  wire drive_status_pkg::drive_stat_t req_in,
   input  wire logic                          transistor_status_in,
   input  wire logic                          relay_status_in,
   // Drive state towards the block, contacts as last seen
   output drive_status_pkg::drive_stat_t      drive_out,
   output logic [1:0]                         contacts_out
);
   always_ff @(posedge sys_clk_in or posedge rst_in)
      if (rst_in)
      begin
         drive_out    <= '0;
         contacts_out <= 2'h0;
      end
      else
      begin
         drive_out    <= req_in;
         contacts_out <= {relay_status_in, transistor_status_in};
      end
endmodule

// File: test/drive_status_checker.sv
`timescale 1ns/1ps
module drive_status_checker
   import drive_status_pkg::*;
#(
   parameter int SEC_TICKS = SEC_CYCLES
)
(
   input wire logic                          sys_clk_in,
   input wire logic                          rst_in,
   input wire drive_status_pkg::apb_req_t    apb_in,
   input wire logic [31:0]                   prdata_out,
   input wire logic                          pready_out,
   input wire logic                          pslverr_out,
   input wire drive_status_pkg::drive_stat_t drive_in,
   input wire logic                          transistor_status_out,
   input wire logic                          relay_status_out,
   input wire logic                          motor_overload_flag_out,
   input wire logic                          output_off_out
);
   // Shadow copies of accepted settings; refused writes leave them alone
   logic        wr_ok;
   logic        clr;
   logic [11:0] lvl_q, bw_q, df0, df2;
   logic [4:0]  ts_q, rs_q;
   logic [2:0]  fm_q;
   logic [7:0]  wl_q;
   logic        ten_q;
   logic [16:8] sv;
   assign wr_ok = apb_in.psel && apb_in.penable && apb_in.pwrite && pready_out && !pslverr_out;
   assign clr = wr_ok && apb_in.paddr == OFS_CTRL && apb_in.pwdata[0];
   assign df0 = drive_in.cmd_freq > drive_in.run_freq ? drive_in.cmd_freq - drive_in.run_freq
                                                      : drive_in.run_freq - drive_in.cmd_freq;
   assign df2 = lvl_q > drive_in.run_freq ? lvl_q - drive_in.run_freq : drive_in.run_freq - lvl_q;
   assign sv = {drive_in.waiting_run, drive_in.speed_search, drive_in.const_speed,
                drive_in.stopped, drive_in.run_cmd && drive_in.output_on, drive_in.ref_lost,
                drive_in.heatsink_hot_flag, drive_in.uv_trip, drive_in.ov_trip};
   always_ff @(posedge sys_clk_in or posedge rst_in)
      if (rst_in)
      begin
         lvl_q <= RST_LEVEL;
         bw_q  <= RST_BW;
         ts_q  <= RST_TR_SEL;
         rs_q  <= RST_RL_SEL;
         fm_q  <= RST_FMASK;
         wl_q  <= RST_WARN_LVL;
         ten_q <= RST_TRIP_EN;
      end
      else if (wr_ok)
      begin
         if (apb_in.paddr == OFS_LEVEL) lvl_q <= apb_in.pwdata[11:0];
         if (apb_in.paddr == OFS_BW) bw_q <= apb_in.pwdata[11:0];
         if (apb_in.paddr == OFS_SEL) ts_q <= apb_in.pwdata[4:0];
         if (apb_in.paddr == OFS_SEL) rs_q <= apb_in.pwdata[12:8];
         if (apb_in.paddr == OFS_FMASK) fm_q <= apb_in.pwdata[2:0];
         if (apb_in.paddr == OFS_WARN) wl_q <= apb_in.pwdata[7:0];
         if (apb_in.paddr == OFS_TRIP) ten_q <= apb_in.pwdata[OL_EN_BIT];
      end
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);
   property p_fdt1; ts_q == 5'h00 |=> transistor_status_out == $past(df0 <= bw_q >> 1); endproperty
   a_fdt1: assert property (p_fdt1) else $error("code 0 output wrong");
   property p_fdt2; ts_q == 5'h01 |=> transistor_status_out ==
      $past(df0 <= (bw_q >> 1) && drive_in.cmd_freq == lvl_q); endproperty
   a_fdt2: assert property (p_fdt2) else $error("code 1 output wrong");
   property p_fdt3; ts_q == 5'h02 |=> transistor_status_out == $past(df2 <= bw_q >> 1); endproperty
   a_fdt3: assert property (p_fdt3) else $error("code 2 output wrong");
   property p_inv; (ts_q == 5'h04 && rs_q == 5'h03) [*3] |-> transistor_status_out !=
      relay_status_out; endproperty
   a_inv: assert property (p_inv) else $error("code 4 not inverse of code 3");
   property p_relay; rs_q inside {[8:16]} |=> relay_status_out == $past(sv[rs_q]); endproperty
   a_relay: assert property (p_relay) else $error("relay state code wrong");
   property p_stop; ts_q == 5'h0D |=> transistor_status_out == $past(drive_in.stopped); endproperty
   a_stop: assert property (p_stop) else $error("stop code wrong");
   property p_fault; rs_q == 5'h11 && !drive_in.ov_trip && !drive_in.heatsink_hot_flag |=>
      relay_status_out == $past(|(fm_q & {drive_in.retry_active, drive_in.other_trip,
      drive_in.uv_trip})); endproperty
   a_fault: assert property (p_fault) else $error("fault output wrong");
   property p_warn; drive_in.motor_current <= wl_q |=> !motor_overload_flag_out; endproperty
   a_warn: assert property (p_warn) else $error("warning not cleared");
   property p_ten; !ten_q && !output_off_out |=> !output_off_out; endproperty
   a_ten: assert property (p_ten) else $error("trip while disabled");
   property p_hold; output_off_out && !clr |=> output_off_out; endproperty
   a_hold: assert property (p_hold) else $error("trip not held");
endmodule
bind drive_status_output_select drive_status_checker #(.SEC_TICKS(SEC_TICKS)) u_chk (
   .sys_clk_in(sys_clk_in), .rst_in(rst_in), .apb_in(apb_in), .prdata_out(prdata_out),
   .pready_out(pready_out), .pslverr_out(pslverr_out), .drive_in(drive_in),
   .transistor_status_out(transistor_status_out), .relay_status_out(relay_status_out),
   .motor_overload_flag_out(motor_overload_flag_out), .output_off_out(output_off_out));

// File: test/test_drive_status_output_select.sv
`timescale 1ns/1ps
module test_drive_status_output_select;
   import drive_status_pkg::*;
   localparam int TICKS = 10;
   logic        sys_clk_in, rst_in, pready, pslverr, tr_out, rl_out, ovl_out, off_out, er;
   apb_req_t    apb_q;
   drive_stat_t dreq, drive_w, d;
   logic [31:0] prdata, rd;
   logic [11:0] lvl = RST_LEVEL;
   logic [11:0] bw = RST_BW;
   logic [4:0]  cl [14] = '{0, 1, 2, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15, 16};
   logic [7:0]  ra [9] = '{OFS_LEVEL, OFS_BW, OFS_SEL, OFS_FMASK, OFS_WARN, OFS_TRIP,
                           OFS_LEVEL, OFS_BW, OFS_SEL};
   logic [31:0] rv [6] = '{32'h0000012C, 32'h00000064, 32'h0000110C, 32'h00000002,
                           32'h00000A96, 32'h00003CB4};
   logic [7:0]  wa [8] = '{OFS_BW, OFS_LEVEL, OFS_SEL, OFS_WARN, OFS_TRIP, OFS_STATUS, 8'h40,
                           OFS_MAXF};
   logic [31:0] wd [8] = '{32'h00000259, 32'h00000259, 32'h00000012, 32'h00000A1D,
                           32'h00003DB4, 32'h00000000, 32'h00000000, 32'h00000FA1};
   logic [11:0] hf [6] = '{12'd200, 12'd290, 12'd300, 12'd260, 12'd250, 12'd299};
   logic        he [6] = '{0, 0, 1, 1, 0, 0};
   int          fail_count = 0;
   int          checked = 0;
   int          cyc = 0;
   int          i, j;

   initial
   begin
      sys_clk_in = 1'b0;
      forever #5 sys_clk_in = ~sys_clk_in;
   end

   drive_seq_model model (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .req_in(dreq),
      .transistor_status_in(tr_out), .relay_status_in(rl_out), .drive_out(drive_w),
      .contacts_out());
   drive_status_output_select #(.SEC_TICKS(TICKS)) dut (.sys_clk_in(sys_clk_in),
      .rst_in(rst_in), .apb_in(apb_q), .prdata_out(prdata), .pready_out(pready),
      .pslverr_out(pslverr), .drive_in(drive_w), .transistor_status_out(tr_out),
      .relay_status_out(rl_out), .motor_overload_flag_out(ovl_out), .output_off_out(off_out));

   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      checked++;
      if (got !== ex)
      begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, ex, got);
      end
   endtask

   // Request held until pready is seen high at an edge, then released
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dat);
      @(posedge sys_clk_in);
      apb_q <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: dat};
      @(posedge sys_clk_in);
      apb_q.penable <= 1'b1;
      do @(posedge sys_clk_in); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      apb_q <= '0;
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge sys_clk_in);
      #1;
   endtask

   task automatic drv(input drive_stat_t v, input int n);
      dreq <= v;
      wt(n);
   endtask

   function automatic logic exp_cond(input logic [4:0] c, input drive_stat_t s);
      logic [11:0] d0, d2;
      d0 = s.cmd_freq > s.run_freq ? s.cmd_freq - s.run_freq : s.run_freq - s.cmd_freq;
      d2 = lvl > s.run_freq ? lvl - s.run_freq : s.run_freq - lvl;
      case (c)
         5'd0: return d0 <= (bw >> 1);
         5'd1: return d0 <= (bw >> 1) && s.cmd_freq == lvl;
         5'd2: return d2 <= (bw >> 1);
         5'd6: return s.drive_overload_flag;
         5'd7: return s.stall;
         5'd8: return s.ov_trip;
         5'd9: return s.uv_trip;
         5'd10: return s.heatsink_hot_flag;
         5'd11: return s.ref_lost;
         5'd12: return s.run_cmd && s.output_on;
         5'd13: return s.stopped;
         5'd14: return s.const_speed;
         5'd15: return s.speed_search;
         5'd16: return s.waiting_run;
         default: return 1'b0;
      endcase
   endfunction

   task automatic complete_run;
      $display("comparisons %0d, mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Whole sequence needs about a thousand cycles
   always @(posedge sys_clk_in)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         fail_count++;
         complete_run();
      end
   end

   initial
   begin
      rst_in = 1'b1;
      apb_q = '0;
      dreq = '0;
      void'($urandom(32'h08DC134E));
      repeat (8) @(posedge sys_clk_in);
      rst_in <= 1'b0;
      for (i = 0; i < 6; i++)
      begin
         apb(1'b0, ra[i], '0);
         chk("reset value", rv[i], rd);
      end
      $display("test reset values done");
      for (i = 0; i < 8; i++)
      begin
         apb(1'b1, wa[i], wd[i]);
         chk("refused write", 1'b1, er);
      end
      for (i = 6; i < 9; i++)
      begin
         apb(1'b0, ra[i], '0);
         chk("unchanged", rv[i - 6], rd);
      end
      apb(1'b1, OFS_BW, 32'h00000258);
      chk("bw at max", 1'b0, er);
      apb(1'b1, OFS_BW, 32'h00000064);
      $display("test refusals done");
      for (i = 0; i < 70; i++)
      begin
         apb(1'b1, OFS_SEL, {19'h0, cl[(i + 5) % 14], 3'h0, cl[i % 14]});
         d = drive_stat_t'({$urandom, $urandom});
         d.cmd_freq = 12'd250 + 12'($urandom_range(0, 100));
         d.run_freq = 12'd250 + 12'($urandom_range(0, 100));
         if (i % 5 == 0) d.cmd_freq = lvl;
         if (i % 3 == 0) d.run_freq = d.cmd_freq + (bw >> 1);
         drv(d, 4);
         chk("transistor", exp_cond(cl[i % 14], d), tr_out);
         chk("relay", exp_cond(cl[(i + 5) % 14], d), rl_out);
      end
      $display("test condition codes done");
      apb(1'b1, OFS_SEL, 32'h00000304);
      for (i = 0; i < 6; i++)
      begin
         d = '0;
         d.run_freq = hf[i];
         drv(d, 5);
         chk("level reached", he[i], rl_out);
         chk("level reached inverse", !he[i], tr_out);
      end
      $display("test hysteresis done");
      apb(1'b1, OFS_SEL, 32'h00001111);
      for (i = 0; i < 8; i++)
      begin
         apb(1'b1, OFS_FMASK, i);
         for (j = 0; j < 3; j++)
         begin
            d = '0;
            {d.retry_active, d.other_trip, d.uv_trip} = 3'h1 << j;
            drv(d, 4);
            chk("fault relay", i[j], rl_out);
            chk("fault transistor", i[j], tr_out);
         end
      end
      $display("test fault mask done");
      apb(1'b1, OFS_SEL, 32'h00001105);
      apb(1'b1, OFS_WARN, 32'h00000264);
      d = '0;
      d.motor_current = 8'd101;
      drv(d, 12);
      chk("warn early", 1'b0, ovl_out);
      wt(18);
      chk("warn", 1'b1, ovl_out);
      chk("warn on output", 1'b1, tr_out);
      d.motor_current = 8'd100;
      drv(d, 4);
      chk("warn cleared", 1'b0, ovl_out);
      $display("test overload warning done");
      apb(1'b1, OFS_TRIP, 32'h00000196);
      d.motor_current = 8'd200;
      drv(d, 40);
      chk("trip disabled", 1'b0, off_out);
      d.motor_current = 8'd100;
      drv(d, 2);
      apb(1'b1, OFS_TRIP, 32'h00010396);
      d.motor_current = 8'd151;
      drv(d, 20);
      d.motor_current = 8'd100;
      drv(d, 2);
      d.motor_current = 8'd151;
      drv(d, 20);
      chk("trip timer restart", 1'b0, off_out);
      wt(25);
      chk("tripped", 1'b1, off_out);
      apb(1'b0, OFS_STATUS, '0);
      chk("trip status", 1'b1, rd[STAT_TRIP_BIT]);
      d.motor_current = 8'd100;
      drv(d, 2);
      apb(1'b1, OFS_CTRL, 32'h00000001);
      wt(2);
      chk("trip cleared", 1'b0, off_out);
      $display("test overload trip done");
      complete_run();
   end
endmodule
